// ==== pawg_wait_gen.v ====
// Peripheral access wait generator with APB control and status
// Function
// RQ1: Stall the CPU whenever it accesses a designated peripheral register.
// RQ2: Watchdog mode register writes stall exactly three CPU clocks.
// RQ3: Reads of either serial receive status register stall one CPU clock.
// RQ4: Converter mode, channel, compare writes stall 2-5 or 2-9 computed clocks.
// RQ5: Converter result reads stall 1-5 or 1-9 computed clocks.
// RQ6: Converter clock is oscillator/2 when divider bit is one, else /4.
// RQ7: Maximum converter wait is twice CPU-to-converter clock ratio, plus one.
// RQ8: Drop a fraction not exceeding the clock low width, else round up.
// RQ9: Computed count of one: no write wait, result read still stalls one.
// RQ10: Waits count in CPU clocks; instruction grows by exactly the wait.
// RQ11: CPU holds the request while stalled; read data returns after the wait.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "pawg_consts.vh"

module pawg_wait_gen #(
  parameter WAIT_WIDTH = 4
) (
  input wire clk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire cpuValid,
  input wire cpuWrite,
  input wire [7:0] cpuAddr,
  input wire [7:0] cpuWdata,
  output reg cpuWait,
  output reg cpuDone,
  output reg [7:0] cpuRdata,
  input wire [7:0] periphRdata,
  output reg periphWe,
  output reg [7:0] periphAddr,
  output reg [7:0] periphWdata
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] cpuClkSel_r;
  reg convDivBit_r;
  reg [31:0] stallCount_r;
  reg [WAIT_WIDTH-1:0] lastWait_r;
  reg [WAIT_WIDTH-1:0] reqWait;
  reg [WAIT_WIDTH-1:0] convWait;
  reg [2:0] sel;
  reg [2:0] expPlusOne;
  reg [3:0] fracEighths;
  reg convRoundUp;
  reg [31:0] readVal;
  reg addrOk;
  wire take;
  wire timerLast;
  wire [WAIT_WIDTH-1:0] timerLeft;
  wire apbAccess;
  wire apbWriteNow;

  // ------------------------------------------------------------
  // Converter wait calculation
  // ------------------------------------------------------------
  // cpuClkSel_r gives the CPU clock as oscillator / 2^sel, sel 0..4.
  always @*
  begin
    sel = (cpuClkSel_r > `PAWG_CTRL_SEL_MAX) ? `PAWG_CTRL_SEL_MAX : cpuClkSel_r;
    // Ratio times two as a power of two: the divide-by-two clock adds one
    // to the exponent, the divide-by-four clock adds two
    expPlusOne = convDivBit_r ? `PAWG_EXP_DIV2 : `PAWG_EXP_DIV4; // [RQ6]
    fracEighths = 4'h0;
    convRoundUp = 1'b0;
    convWait = {WAIT_WIDTH{1'b0}};
    if (sel <= expPlusOne)
    begin
      // Whole doubled ratio (ratio of one half or more): 2*ratio + 1
      convWait = (({{(WAIT_WIDTH-1){1'b0}}, 1'b1}) << (expPlusOne - sel))
        + {{(WAIT_WIDTH-1){1'b0}}, 1'b1}; // [RQ7]
    end
    else
    begin
      // Fractional part below one clock, kept in eighths of a period
      fracEighths = `PAWG_PERIOD_EIGHTHS >> (sel - expPlusOne);
      // Equal to the low width counts as not exceeding it, so it is dropped
      convRoundUp = (fracEighths > `PAWG_LOW_WIDTH_EIGHTHS); // [RQ8]
      convWait = {{(WAIT_WIDTH-1){1'b0}}, 1'b1}
        + {{(WAIT_WIDTH-1){1'b0}}, convRoundUp}; // [RQ7]
    end
  end

  // ------------------------------------------------------------
  // Wait per register and access direction
  // ------------------------------------------------------------
  always @*
  begin
    reqWait = {WAIT_WIDTH{1'b0}};
    if (cpuWrite)
    begin
      case (cpuAddr)
        `PAWG_ADDR_WATCHDOG_MODE:
        begin
          reqWait = `PAWG_WAIT_WATCHDOG; // [RQ2]
        end
        `PAWG_ADDR_CONV_MODE, `PAWG_ADDR_CONV_CHANNEL,
        `PAWG_ADDR_COMPARE_MODE, `PAWG_ADDR_COMPARE_THRESHOLD:
        begin
          // A computed count of one means no wait at all for writes
          if (convWait == {{(WAIT_WIDTH-1){1'b0}}, 1'b1})
          begin
            reqWait = {WAIT_WIDTH{1'b0}}; // [RQ9]
          end
          else
          begin
            reqWait = convWait; // [RQ4]
          end
        end
        default:
        begin
          reqWait = {WAIT_WIDTH{1'b0}};
        end
      endcase
    end
    else
    begin
      case (cpuAddr)
        `PAWG_ADDR_SERIAL_A_RX_STATUS, `PAWG_ADDR_SERIAL_B_RX_STATUS:
        begin
          reqWait = `PAWG_WAIT_SERIAL_RX; // [RQ3]
        end
        `PAWG_ADDR_CONV_RESULT:
        begin
          // Never below one, so a count of one still stalls reads
          reqWait = convWait; // [RQ5] [RQ9]
        end
        default:
        begin
          reqWait = {WAIT_WIDTH{1'b0}};
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Stall sequencer
  // ------------------------------------------------------------
  assign take = (state_r == ST_IDLE) && cpuValid;

  pawg_wait_timer #(
    .WIDTH(WAIT_WIDTH)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .load(take),
    .loadVal(reqWait),
    .lastCycle(timerLast),
    .remaining(timerLeft)
  );

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (cpuValid)
        begin
          if (reqWait != {WAIT_WIDTH{1'b0}})
          begin
            state_nxt = ST_WAIT; // [RQ1]
          end
          else
          begin
            state_nxt = ST_DONE;
          end
        end
      end
      ST_WAIT:
      begin
        // Leave after exactly the loaded number of cycles
        if (timerLast)
        begin
          state_nxt = ST_DONE; // [RQ10]
        end
      end
      ST_DONE:
      begin
        state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      cpuWait <= 1'b0;
      cpuDone <= 1'b0;
      cpuRdata <= 8'h00;
      periphWe <= 1'b0;
      periphAddr <= 8'h00;
      periphWdata <= 8'h00;
      convDivBit_r <= `PAWG_DIV_BIT_RESET;
      lastWait_r <= {WAIT_WIDTH{1'b0}};
    end
    else
    begin
      state_r <= state_nxt;
      cpuWait <= (state_nxt == ST_WAIT); // [RQ1] [RQ10]
      cpuDone <= (state_nxt == ST_DONE);
      periphWe <= 1'b0;
      if (take)
      begin
        lastWait_r <= reqWait;
      end
      // Request is sampled only when the stall ends, since the CPU holds it
      if (state_nxt == ST_DONE)
      begin
        periphAddr <= cpuAddr;
        if (cpuWrite)
        begin
          periphWe <= 1'b1;
          periphWdata <= cpuWdata;
          // The new divider setting governs only the following accesses
          if (cpuAddr == `PAWG_ADDR_CONV_MODE)
          begin
            convDivBit_r <= cpuWdata[`PAWG_DIV_BIT_POS]; // [RQ6]
          end
        end
        else
        begin
          cpuRdata <= periphRdata; // [RQ11]
        end
      end
    end
  end

  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  // One wait state: pready rises in the second access cycle so that
  // prdata can come straight from a flip-flop.
  assign apbAccess = psel && penable;
  assign apbWriteNow = apbAccess && pready && pwrite;

  always @*
  begin
    addrOk = 1'b1;
    readVal = 32'h00000000;
    case (paddr)
      `PAWG_APB_CTRL:
      begin
        readVal = {29'h00000000, cpuClkSel_r};
      end
      `PAWG_APB_STATUS:
      begin
        readVal = {20'h00000, timerLeft, 1'b0, convDivBit_r, 5'h00, cpuWait};
      end
      `PAWG_APB_STALLS:
      begin
        readVal = stallCount_r;
      end
      `PAWG_APB_LASTWAIT:
      begin
        readVal = {{(32-WAIT_WIDTH){1'b0}}, lastWait_r};
      end
      default:
      begin
        addrOk = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      cpuClkSel_r <= `PAWG_CTRL_RESET;
    end
    else
    begin
      if (apbAccess && !pready)
      begin
        pready <= 1'b1;
        pslverr <= !addrOk;
        prdata <= pwrite ? 32'h00000000 : readVal;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      if (apbWriteNow && (paddr == `PAWG_APB_CTRL))
      begin
        cpuClkSel_r <= pwdata[2:0];
      end
    end
  end

  // Stall cycle counter; a stall cycle in the clearing cycle is kept
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stallCount_r <= 32'h00000000;
    end
    else if (apbWriteNow && (paddr == `PAWG_APB_STALLS))
    begin
      stallCount_r <= {31'h00000000, cpuWait};
    end
    else if (cpuWait)
    begin
      stallCount_r <= stallCount_r + 32'h00000001;
    end
  end

endmodule

`default_nettype wire

// ==== pawg_consts.vh ====
// Constants for the peripheral access wait generator
`ifndef PAWG_CONSTS_VH
`define PAWG_CONSTS_VH

// ------------------------------------------------------------
// APB register map (byte addresses)
// ------------------------------------------------------------
`define PAWG_APB_CTRL 12'h000
`define PAWG_APB_STATUS 12'h004
`define PAWG_APB_STALLS 12'h008
`define PAWG_APB_LASTWAIT 12'h00C
`define PAWG_CTRL_RESET 3'h0
`define PAWG_CTRL_SEL_MAX 3'h4

// ------------------------------------------------------------
// CPU-side peripheral register addresses
// ------------------------------------------------------------
`define PAWG_ADDR_WATCHDOG_MODE 8'h48
`define PAWG_ADDR_SERIAL_A_RX_STATUS 8'h71
`define PAWG_ADDR_SERIAL_B_RX_STATUS 8'h53
`define PAWG_ADDR_CONV_MODE 8'h80
`define PAWG_ADDR_CONV_CHANNEL 8'h81
`define PAWG_ADDR_COMPARE_MODE 8'h82
`define PAWG_ADDR_COMPARE_THRESHOLD 8'h83
`define PAWG_ADDR_CONV_RESULT 8'h84

// ------------------------------------------------------------
// Wait figures
// ------------------------------------------------------------
`define PAWG_WAIT_WATCHDOG 4'h3
`define PAWG_WAIT_SERIAL_RX 4'h1
`define PAWG_DIV_BIT_POS 5
`define PAWG_DIV_BIT_RESET 1'b0
// Converter clock is fx/2 or fx/4: exponent plus one of the ratio factor 2
`define PAWG_EXP_DIV2 3'h2
`define PAWG_EXP_DIV4 3'h3
// Eighths of a CPU period: full period and low-level width (50 % duty)
`define PAWG_PERIOD_EIGHTHS 4'h8
`define PAWG_LOW_WIDTH_EIGHTHS 4'h4

`endif

// ==== pawg_wait_timer.v ====
// Down-counter that times one stall in CPU clock cycles
`timescale 1ns/1ns
`default_nettype none

module pawg_wait_timer #(
  parameter WIDTH = 4
) (
  input wire clk,
  input wire resetn,
  input wire load,
  input wire [WIDTH-1:0] loadVal,
  output wire lastCycle,
  output wire [WIDTH-1:0] remaining
);

  reg [WIDTH-1:0] count_r;
  reg [WIDTH-1:0] count_nxt;

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  always @*
  begin
    count_nxt = count_r;
    if (load)
    begin
      count_nxt = loadVal;
    end
    else if (count_r != {WIDTH{1'b0}})
    begin
      count_nxt = count_r - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r <= {WIDTH{1'b0}};
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  assign lastCycle = (count_r == {{(WIDTH-1){1'b0}}, 1'b1});
  assign remaining = count_r;

endmodule

`default_nettype wire

// ==== pawg_wait_gen_chk.sv ====
// Assertions on the CPU side of the wait generator
`timescale 1ns/1ns
`default_nettype none
module pawg_wait_gen_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpuValid,
  input wire logic cpuWrite,
  input wire logic [7:0] cpuAddr,
  input wire logic cpuWait,
  input wire logic cpuDone,
  input wire logic [7:0] cpuRdata,
  input wire logic [7:0] periphRdata,
  input wire logic periphWe,
  input wire logic [7:0] periphAddr
);
  // ----
  // Request tracking
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic busyR;
  wire take = cpuValid && !busyR;
  wire convWr = cpuWrite && cpuAddr[7:2] == 6'h20;
  // Busy covers the done cycle, so a still-held request is not taken twice
  always @(posedge clk or negedge resetn)
    if (!resetn)
      busyR <= 1'b0;
    else
      busyR <= take || (busyR && !cpuDone);
  sequence s_end;
    !cpuWait && cpuDone;
  endsequence
  sequence s_stall3;
    cpuWait [*3] ##1 s_end;
  endsequence
  a_watchdog_three: assert property (take && cpuWrite && cpuAddr == 8'h48 |=> s_stall3)
    else $error("watchdog stall length wrong");
  a_serial_one: assert property (take && !cpuWrite && (cpuAddr == 8'h71 || cpuAddr == 8'h53)
    |=> cpuWait ##1 s_end)
    else $error("serial status stall length wrong");
  a_plain_nowait: assert property (take && cpuAddr[7:4] == 4'h0 |=> s_end)
    else $error("unlisted access stalled");
  a_result_stalls: assert property (take && !cpuWrite && cpuAddr == 8'h84 |=> cpuWait)
    else $error("result read not stalled");
  a_conv_bound: assert property (take && convWr |-> ##[1:10] cpuDone)
    else $error("converter write stall too long");
  a_conv_nosingle: assert property (take && convWr |=> not (cpuWait ##1 s_end))
    else $error("converter write stalled one clock");
  a_wait_done: assert property ($fell(cpuWait) |-> cpuDone)
    else $error("stall end without completion");
  a_done_pulse: assert property (cpuDone |=> !cpuDone)
    else $error("completion longer than one cycle");
  a_write_strobe: assert property (cpuDone |-> periphWe == cpuWrite && periphAddr == cpuAddr)
    else $error("peripheral strobe or address wrong");
  a_read_data: assert property (cpuDone && !cpuWrite |-> cpuRdata == $past(periphRdata))
    else $error("read data wrong");
endmodule
bind pawg_wait_gen pawg_wait_gen_chk i_chk (.clk(clk), .resetn(resetn), .cpuValid(cpuValid),
  .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .cpuWait(cpuWait), .cpuDone(cpuDone),
  .cpuRdata(cpuRdata), .periphRdata(periphRdata), .periphWe(periphWe), .periphAddr(periphAddr));
`default_nettype wire

// ==== pawg_cpu_model.sv ====
// CPU core model issuing held peripheral accesses
`timescale 1ns/1ns
`default_nettype none
module pawg_cpu_model (
  input wire logic clk,
  input wire logic cpuDone,
  output var logic cpuValid,
  output var logic cpuWrite,
  output var logic [7:0] cpuAddr,
  output var logic [7:0] cpuWdata
);
  initial
  begin
    cpuValid = 1'b0;
    cpuWrite = 1'b0;
    cpuAddr = 8'h00;
    cpuWdata = 8'h00;
  end
  // Returns the wait count beyond the no-wait length
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output int n);
    n = 0;
    cpuValid <= 1'b1;
    cpuWrite <= w;
    cpuAddr <= a;
    cpuWdata <= d;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (cpuDone !== 1'b1 && n < 20);
    @(posedge clk);
    // Released address and data lines show inverted values, never the stale ones; cpuWrite keeps its value
    cpuValid <= 1'b0;
    cpuAddr <= ~a;
    cpuWdata <= ~d;
    @(posedge clk);
    n = n - 2;
  endtask
endmodule
`default_nettype wire

// ==== test_peripheral_access_wait_generator.sv ====
// Testbench for the peripheral access wait generator
`timescale 1ns/1ns
`default_nettype none
module test_peripheral_access_wait_generator;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, cpuValid, cpuWrite, cpuWait, cpuDone, periphWe;
  logic [7:0] cpuAddr, cpuWdata, cpuRdata, periphAddr, periphWdata, periphRdata = 8'h5A;
  logic [7:0] doneData = 8'h00;
  int nMismatch = 0, compares = 0, cycles = 0;
  int waitTbl[2][5] = '{'{9, 5, 3, 2, 1}, '{5, 3, 2, 1, 1}};
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    periphRdata <= periphRdata + 8'h1D;
    // Peripheral data as it stood at the edge that raises the completion pulse
    if (cpuDone !== 1'b1)
      doneData <= periphRdata;
    cycles++;
    if (cycles == 3000)
    begin
      nMismatch++;
      finish_test();
    end
  end
  pawg_wait_gen i_pawg_wait_gen (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpuValid(cpuValid), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
    .cpuWdata(cpuWdata), .cpuWait(cpuWait), .cpuDone(cpuDone), .cpuRdata(cpuRdata),
    .periphRdata(periphRdata), .periphWe(periphWe), .periphAddr(periphAddr),
    .periphWdata(periphWdata));
  pawg_cpu_model i_pawg_cpu_model (.clk(clk), .cpuDone(cpuDone), .cpuValid(cpuValid),
    .cpuWrite(cpuWrite), .cpuAddr(cpuAddr), .cpuWdata(cpuWdata));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task cpu(input logic w, input logic [7:0] a, input logic [7:0] d, input int exp);
    int n;
    i_pawg_cpu_model.access(w, a, d, n);
    chk(n, exp);
    chk(periphAddr, a);
    if (w)
      chk(periphWdata, d);
    else
      chk(cpuRdata, doneData);
  endtask
  task t_regs;
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'b1, 12'h000, 32'h3, r, e);
    apb(1'b0, 12'h000, 32'h0, r, e);
    chk(r, 32'h3);
    apb(1'b1, 12'h010, 32'h7, r, e);
    chk(e, 1'b1);
  endtask
  task t_fixed;
    logic [31:0] r;
    logic e;
    apb(1'b1, 12'h008, 32'h0, r, e);
    cpu(1'b1, 8'h48, 8'hA5, 3);
    cpu(1'b1, 8'h48, 8'h5A, 3);
    apb(1'b0, 12'h008, 32'h0, r, e);
    chk(r, 32'h6);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    chk(r, 32'h3);
    cpu(1'b0, 8'h71, 8'h00, 1);
    cpu(1'b0, 8'h53, 8'h00, 1);
    cpu(1'b1, 8'h71, 8'h00, 0);
    cpu(1'b0, 8'h48, 8'h00, 0);
    cpu(1'b0, 8'h05, 8'h00, 0);
  endtask
  // Sweeps every CPU clock choice for both divider settings
  task t_conv;
    logic [31:0] r;
    logic e;
    int w, n, p;
    for (int d = 0; d < 2; d++)
      for (int s = 0; s < 5; s++)
      begin
        apb(1'b1, 12'h000, 32'(s), r, e);
        i_pawg_cpu_model.access(1'b1, 8'h80, {2'b0, d[0], 5'h0}, n);
        // The mode write itself is timed with the divider bit it replaces
        p = waitTbl[s == 0 ? 0 : d][s];
        chk(n, p == 1 ? 0 : p);
        apb(1'b0, 12'h004, 32'h0, r, e);
        chk(r[6], d[0]);
        w = waitTbl[d][s];
        for (int a = 0; a < 5; a++)
          cpu(a != 4, 8'(128 + a), {2'b0, d[0], 5'h0}, a == 4 ? w : (w == 1 ? 0 : w));
      end
  endtask
  task finish_test;
    $display("mismatches %0d, compares %0d", nMismatch, compares);
    if (nMismatch == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_fixed();
    t_conv();
    finish_test();
  end
endmodule
`default_nettype wire
